// file: dv/pss_chk.sv
// Link checks for the sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_chk (
   input wire logic                     core_clk_i,
   input wire logic                     rst_i,
   input wire pss_pkg::pss_lines_t      lines,
   input wire logic                     frame_trig,
   input wire pss_pkg::pss_ctrl_t       cfg,
   input wire pss_pkg::pss_cmd_t        cmd,
   input wire logic                     waiting,
   input wire logic [pss_pkg::PW-1:0]   act_param,
   input wire logic [pss_pkg::IW-1:0]   act_idx
);
   import pss_pkg::*;
   // ----
   // Checks
   // ----
   logic [1:0] adr;
   // Two sets: the high address line is not looked at
   assign adr = {(cfg.count != TWO_SETS) & (lines[cfg.a1sel] ^ cfg.inv1), lines[cfg.a0sel] ^ cfg.inv0};
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   chk_trig_when_wait: assert property ($rose(frame_trig) |-> $past(waiting)) else $error("trig busy");
   chk_lines_hold: assert property ($rose(frame_trig) |-> $stable(lines) [*8]) else $error("hold");
   chk_lines_setup: assert property ($changed(lines) |-> !frame_trig [*8]) else $error("setup");
   chk_change_drops: assert property ($changed(adr) && cfg.on && cfg.free
      |-> ##[1:6] !waiting) else $error("drop");
   chk_sync_delay: assert property ($rose(frame_trig) && waiting |=> waiting) else $error("sync");
   chk_trig_taken: assert property ($rose(frame_trig) && waiting |-> ##[1:6] !waiting) else $error("take");
   chk_bad_ptr: assert property (cmd.load && !cfg.on && !cfg.free && {1'b0, cfg.ptr} >= cfg.count
      |=> $stable(act_param) [*3]) else $error("bad ptr");
   chk_free_index: assert property ($rose(frame_trig) && waiting && cfg.on && cfg.free
      |-> ##[2:8] act_idx == {4'h0, adr}) else $error("index");
   cover property ($rose(frame_trig) && cfg.free);
   cover property (cmd.store);
   cover property (cmd.advance);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Bench for the sequencer host and device pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
   import pss_pkg::*;
   // ----
   // Harness
   // ----
   logic        clk = 0, rst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, fa;
   logic [15:0] ap;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, sd;
   logic [1:0]  bresp, rresp, rs;
   int          mismatches = 0, n_checks = 0;
   pss_ctrl_t   c;
   // Table: inv0, two sets, lines, set picked
   logic [7:0]  tv [6] = '{8'h00, 8'h05, 8'h0A, 8'h0F, 8'h81, 8'h48};
   pss_if ifc ();
   always #2.5 clk = ~clk;
   pss_host u_pss_host (.core_clk_i(clk), .rst_i(rst_i), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
      .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hF), .bvalid_o(bvalid), .bready_i(bready),
      .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid),
      .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .lnk(ifc.host));
   // Short frame keeps each trigger cheap
   pss_device #(.FRAME_LEN(4)) u_pss_device (.core_clk_i(clk), .rst_i(rst_i), .lnk(ifc.dev), .active_param_o(ap),
      .frame_active_o(fa));
   pss_chk u_pss_chk (.core_clk_i(clk), .rst_i(rst_i), .lines(ifc.lines), .frame_trig(ifc.frame_trig), .cfg(ifc.cfg),
      .cmd(ifc.cmd), .waiting(ifc.waiting), .act_param(ifc.act_param), .act_idx(ifc.act_idx));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'h1;
      fork
         begin do @(posedge clk); while (!awready); awvalid <= 1'h0; end
         begin do @(posedge clk); while (!wready); wvalid <= 1'h0; end
      join
      do @(posedge clk); while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (!rvalid);
      sd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   task automatic wc(input pss_ctrl_t v);
      wr(OFS_CTRL, {7'h0, v});
   endtask
   task automatic cm(input int b);
      wr(OFS_CMD, 32'h1 << b);
   endtask
   task automatic sp(input logic [15:0] v);
      wr(OFS_PARAM, {16'h0, v});
      cm(6);
   endtask
   // Polls until idle with the wanted value, bounded
   task automatic pw(input logic [15:0] e);
      for (int k = 0; k < 300; k++) begin
         rd(OFS_STATUS);
         if (sd[1:0] === 2'b01 && ifc.frame_trig === 1'b0 && sd[31:16] === e) break;
      end
      `CHK("param", e, sd[31:16])
      `CHK("out", e, ap)
      `CHK("frame", 1'b0, fa)
   endtask
   task automatic results();
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_i <= 1'h0;
      rd(OFS_STATUS);
      `CHK("status", 32'h1, sd)
      rd(8'h14);
      `CHK("rresp", RESP_ERR, rs)
      c = '0;
      c.count = MAX_FREE;
      for (int i = 0; i < 4; i++) begin
         c.ptr = 6'(i);
         wc(c);
         sp(16'hA000 + 16'(i));
         cm(1);
      end
      c.ptr = 6'h2;
      wc(c);
      cm(2);
      pw(16'hA002);
      sp(16'h00FF);
      c.ptr = 6'h5;
      wc(c);
      cm(2);
      pw(16'h00FF);
      c.count = 7'h06;
      wc(c);
      cm(2);
      pw(16'h0000);
      sp(16'h5555);
      foreach (tv[i]) begin
         wc('0);
         c = '0;
         c.free = 1'h1;
         c.a1sel = 2'h1;
         c.inv0 = tv[i][7];
         c.count = tv[i][6] ? TWO_SETS : MAX_FREE;
         wc(c);
         c.on = 1'h1;
         wc(c);
         wr(OFS_LINES, {28'h0, tv[i][5:2]});
         cm(5);
         pw(16'hA000 + 16'(tv[i][1:0]));
      end
      wc('0);
      pw(16'h5555);
      c = '0;
      c.count = MAX_FREE;
      c.src = SRC_ALWAYS;
      wc(c);
      cm(0);
      c.on = 1'h1;
      wc(c);
      pw(16'hA000);
      cm(3);
      pw(16'hA001);
      cm(4);
      pw(16'hA000);
      cm(5);
      pw(16'hA001);
      results();
   end
endmodule
`default_nettype wire

// file: rtl/pss_device.sv
// Sequencer device: stored sets, active set, trigger and address handling
`timescale 1ns/1ps
`default_nettype none
module pss_device #(
   parameter int FRAME_LEN = pss_pkg::FRAME_CYC
) (
   // Clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   // Link
   pss_if.dev                      lnk,
   // Sensor side
   output logic [pss_pkg::PW-1:0]  active_param_o,
   output logic                    frame_active_o
);
   import pss_pkg::*;

   //---------------------------------------------------------------
   // Pin synchronisation
   //---------------------------------------------------------------
   logic [4:0]    pin_s;
   logic [4:0]    pin_d_r;
   pss_lines_t    ln;
   logic          trig_s;
   pss_sync #(.W(5)) u_sync (           // [RULE21]
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .d_i   ({lnk.frame_trig, lnk.lines}),
      .q_o   (pin_s)
   );
   assign ln     = pss_lines_t'(pin_s[3:0]);
   assign trig_s = pin_s[4];

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_d_r <= 5'h00;
      end else begin
         pin_d_r <= pin_s;
      end
   end

   //---------------------------------------------------------------
   // Configuration
   //---------------------------------------------------------------
   pss_ctrl_t     cf;
   logic [SW-1:0] adv_src_r;
   logic [SW-1:0] rst_src_r;
   logic [CW-1:0] cnt_eff;
   logic          ptr_ok;
   assign cf = lnk.cfg;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         adv_src_r <= SRC_OFF;
         rst_src_r <= SRC_OFF;
      end else if (lnk.cmd.src_wr) begin
         if (!cf.target) begin
            adv_src_r <= cf.src;                         // [RULE2]
         end else if (cf.src != SRC_ALWAYS) begin
            rst_src_r <= cf.src;                         // [RULE3]
         end
      end
   end

   // Count is clamped to what the current mode can address
   always_comb begin
      if (cf.free) begin
         cnt_eff = (cf.count > MAX_FREE) ? MAX_FREE : cf.count;  // [RULE11]
      end else begin
         cnt_eff = (cf.count > MAX_CTRL) ? MAX_CTRL : cf.count;  // [RULE1]
      end
   end
   assign ptr_ok = ({1'b0, cf.ptr} < cnt_eff);          // [RULE5] [RULE22]

   function automatic logic src_level(input logic [SW-1:0] s, input pss_lines_t l);
      case (s)
         SRC_ALWAYS: src_level = 1'b1;
         SRC_LINE1:  src_level = l.line1;
         SRC_CCA:    src_level = l.a;
         SRC_CCB:    src_level = l.b;
         SRC_CCC:    src_level = l.c;
         default:    src_level = 1'b0;                   // [RULE18]
      endcase
   endfunction

   function automatic logic pick(input logic [1:0] s, input pss_lines_t l);
      pick = l[s];
   endfunction

   //---------------------------------------------------------------
   // Free selection address
   //---------------------------------------------------------------
   pss_lines_t    ln_d;
   logic          abit0;
   logic          abit1;
   logic [IW-1:0] faddr;
   logic          addr_chg;
   logic          two_only;
   assign ln_d     = pss_lines_t'(pin_d_r[3:0]);
   assign two_only = (cnt_eff == TWO_SETS);
   assign abit0    = pick(cf.a0sel, ln) ^ cf.inv0;                     // [RULE20] [RULE13]
   assign abit1    = two_only ? 1'b0 : (pick(cf.a1sel, ln) ^ cf.inv1); // [RULE12] [RULE20]
   assign faddr    = {{(IW-2){1'b0}}, abit1, abit0};                   // [RULE19]
   assign addr_chg = cf.on & cf.free &
                     ((pick(cf.a0sel, ln) != pick(cf.a0sel, ln_d)) |
                      (!two_only & (pick(cf.a1sel, ln) != pick(cf.a1sel, ln_d))));

   //---------------------------------------------------------------
   // Stored sets
   //---------------------------------------------------------------
   logic [PW-1:0] sets_r [NSET];
   logic [NSET-1:0] written_r;
   logic [PW-1:0] active_r;
   logic [PW-1:0] backup_r;
   logic [IW-1:0] idx_r;

   function automatic logic [PW-1:0] rd(input logic [IW-1:0] i);
      rd = written_r[i] ? sets_r[i] : DEF_PARAM;          // [RULE6]
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (lnk.cmd.store && ptr_ok) begin
         sets_r[cf.ptr] <= active_r;                       // [RULE7]
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         written_r <= '0;
      end else if (lnk.cmd.store && ptr_ok) begin
         written_r[cf.ptr] <= 1'b1;
      end
   end

   //---------------------------------------------------------------
   // Sequencing state
   //---------------------------------------------------------------
   pss_state_t    st_r;
   logic [TW-1:0] tmr_r;
   logic          on_d_r;
   logic          load_pend_r;
   logic [IW-1:0] load_idx_r;
   logic          restore_pend_r;
   logic          trig_rise;
   logic          on_rise;
   logic          on_fall;
   logic [IW-1:0] idx_inc;
   logic          sync_adv;
   logic          sync_rst;
   assign trig_rise = trig_s & ~pin_d_r[4];
   assign on_rise   = cf.on & ~on_d_r;
   assign on_fall   = ~cf.on & on_d_r;
   assign idx_inc   = ({1'b0, idx_r + IDX_ONE} >= cnt_eff) ? '0 : idx_r + IDX_ONE;
   assign sync_adv  = src_level(adv_src_r, ln);          // [RULE2]
   assign sync_rst  = src_level(rst_src_r, ln);          // [RULE3]

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r  <= PSS_WAIT;
         tmr_r <= '0;
      end else begin
         case (st_r)
            PSS_WAIT: begin
               if (addr_chg) begin
                  st_r  <= PSS_SETTLE;                     // [RULE15]
                  tmr_r <= TW'(SETTLE_CYC);
               end else if (trig_rise) begin
                  st_r  <= PSS_FRAME;
                  tmr_r <= TW'(FRAME_LEN);
               end else if (load_pend_r || restore_pend_r) begin
                  st_r <= PSS_LOAD;
               end
            end
            PSS_FRAME: begin
               if (tmr_r == '0) begin
                  st_r <= PSS_WAIT;
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            PSS_SETTLE: begin
               if (addr_chg) begin
                  tmr_r <= TW'(SETTLE_CYC);                // [RULE15]
               end else if (tmr_r == '0) begin
                  st_r <= PSS_WAIT;
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            default: begin
               st_r <= PSS_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         on_d_r <= 1'b0;
      end else begin
         on_d_r <= cf.on;
      end
   end

   // Pending load: new requests win over the clear in the same cycle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_pend_r <= 1'b0;
         load_idx_r  <= '0;
      end else begin
         if (st_r == PSS_LOAD) begin
            load_pend_r <= 1'b0;
         end
         if (on_rise && !cf.free) begin
            load_pend_r <= 1'b1;
            load_idx_r  <= '0;
         end else if (cf.on && !cf.free && lnk.cmd.restart) begin
            load_pend_r <= 1'b1;                           // [RULE18]
            load_idx_r  <= '0;
         end else if (cf.on && !cf.free && lnk.cmd.advance) begin
            load_pend_r <= 1'b1;                           // [RULE18]
            load_idx_r  <= idx_inc;
         end else if (cf.on && !cf.free && st_r == PSS_WAIT && trig_rise && !addr_chg) begin
            if (sync_rst) begin
               load_pend_r <= 1'b1;
               load_idx_r  <= '0;
            end else if (sync_adv) begin
               load_pend_r <= 1'b1;
               load_idx_r  <= idx_inc;
            end
         end
      end
   end

   // Restore waits for the running frame to finish
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         restore_pend_r <= 1'b0;
      end else if (on_fall) begin
         restore_pend_r <= 1'b1;                           // [RULE17]
      end else if (st_r == PSS_LOAD) begin
         restore_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         backup_r <= DEF_PARAM;
      end else if (on_rise) begin
         backup_r <= active_r;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         active_r <= DEF_PARAM;
         idx_r    <= '0;
      end else if (st_r == PSS_LOAD && restore_pend_r && !cf.on) begin
         active_r <= backup_r;                             // [RULE17]
      end else if (st_r == PSS_LOAD && load_pend_r && cf.on) begin
         active_r <= rd(load_idx_r);
         idx_r    <= load_idx_r;
      end else if (cf.on && cf.free && st_r == PSS_WAIT && trig_rise && !addr_chg) begin
         active_r <= rd(faddr);                            // [RULE10]
         idx_r    <= faddr;
      end else if (lnk.cmd.load && ptr_ok) begin
         active_r <= rd(cf.ptr);                           // [RULE9]
         idx_r    <= cf.ptr;
      end else if (lnk.cmd.param_wr) begin
         active_r <= lnk.param_wdata;
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lnk.waiting    <= 1'b0;
         lnk.act_param  <= DEF_PARAM;
         lnk.act_idx    <= '0;
         active_param_o <= DEF_PARAM;
         frame_active_o <= 1'b0;
      end else begin
         lnk.waiting    <= (st_r == PSS_WAIT) && !addr_chg && !load_pend_r && !restore_pend_r; // [RULE15]
         lnk.act_param  <= active_r;
         lnk.act_idx    <= idx_r;
         active_param_o <= active_r;
         frame_active_o <= (st_r == PSS_FRAME);
      end
   end
endmodule
`default_nettype wire

// file: rtl/pss_host.sv
// Host controller: AXI4-Lite registers driving the sequencer link
`timescale 1ns/1ps
`default_nettype none
module pss_host (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // AXI4-Lite slave
   input  wire logic        awvalid_i,
   output logic             awready_o,
   input  wire logic [7:0]  awaddr_i,
   input  wire logic        wvalid_i,
   output logic             wready_o,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  wstrb_i,
   output logic             bvalid_o,
   input  wire logic        bready_i,
   output logic [1:0]       bresp_o,
   input  wire logic        arvalid_i,
   output logic             arready_o,
   input  wire logic [7:0]  araddr_i,
   output logic             rvalid_o,
   input  wire logic        rready_i,
   output logic [31:0]      rdata_o,
   output logic [1:0]       rresp_o,
   // Link
   pss_if.host              lnk
);
   import pss_pkg::*;

   //---------------------------------------------------------------
   // Write channel
   //---------------------------------------------------------------
   logic          aw_ok_r;
   logic          w_ok_r;
   logic [7:0]    wa_r;
   logic [31:0]   wd_r;
   logic          do_wr;
   pss_ctrl_t     nc;
   logic [TW-1:0] chg_tmr_r;
   logic [TW-1:0] hold_tmr_r;
   logic          trig_pend_r;
   pss_cmd_t      wc;
   logic [SW-1:0] adv_sh_r;
   logic [SW-1:0] rst_sh_r;
   assign do_wr = aw_ok_r & w_ok_r & ~bvalid_o;
   assign nc    = pss_ctrl_t'(wd_r[$bits(pss_ctrl_t)-1:0]);
   assign wc    = pss_cmd_t'(wd_r[$bits(pss_cmd_t)-1:0]);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_ok_r   <= 1'b0;
         w_ok_r    <= 1'b0;
         wa_r      <= 8'h00;
         wd_r      <= 32'h0000_0000;
         awready_o <= 1'b0;
         wready_o  <= 1'b0;
         bvalid_o  <= 1'b0;
         bresp_o   <= RESP_OK;
      end else begin
         awready_o <= ~aw_ok_r & ~(awvalid_i & awready_o);
         wready_o  <= ~w_ok_r & ~(wvalid_i & wready_o);
         if (awvalid_i && awready_o) begin
            aw_ok_r <= 1'b1;
            wa_r    <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_ok_r <= 1'b1;
            wd_r   <= wdata_i;
         end
         if (do_wr) begin
            bvalid_o <= 1'b1;
            bresp_o  <= (wa_r <= OFS_PARAM && wa_r[1:0] == 2'h0) ? RESP_OK : RESP_ERR;
         end
         if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
            aw_ok_r  <= 1'b0;
            w_ok_r   <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------
   // Link drive
   //---------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lnk.cfg         <= '0;
         lnk.lines       <= '0;
         lnk.param_wdata <= DEF_PARAM;
      end else if (do_wr && wstrb_i == 4'hF) begin
         if (wa_r == OFS_CTRL) begin
            if (lnk.cfg.on) begin
               lnk.cfg.on <= nc.on;                        // [RULE8]
            end else begin
               lnk.cfg <= nc;
            end
         end else if (wa_r == OFS_LINES && hold_tmr_r == '0) begin
            lnk.lines <= pss_lines_t'(wd_r[$bits(pss_lines_t)-1:0]); // [RULE14]
         end else if (wa_r == OFS_PARAM) begin
            lnk.param_wdata <= wd_r[PW-1:0];
         end
      end
   end

   // Commands are one-cycle pulses; refused ones simply do not pulse
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lnk.cmd <= '0;
      end else begin
         lnk.cmd <= '0;
         if (do_wr && wa_r == OFS_CMD) begin
            lnk.cmd.src_wr   <= wc.src_wr & ~lnk.cfg.on & (lnk.cfg.src == SRC_OFF ||
                                lnk.cfg.src != (lnk.cfg.target ? adv_sh_r : rst_sh_r)); // [RULE4]
            lnk.cmd.store    <= wc.store & ~lnk.cfg.on;    // [RULE8]
            lnk.cmd.load     <= wc.load;
            lnk.cmd.advance  <= wc.advance;
            lnk.cmd.restart  <= wc.restart;
            lnk.cmd.param_wr <= wc.param_wr;
         end
      end
   end

   // Device's sources, for the clash check
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         adv_sh_r <= SRC_OFF;
         rst_sh_r <= SRC_OFF;
      end else if (lnk.cmd.src_wr && !lnk.cfg.target) begin
         adv_sh_r <= lnk.cfg.src;
      end else if (lnk.cmd.src_wr && lnk.cfg.src != SRC_ALWAYS) begin
         rst_sh_r <= lnk.cfg.src;
      end
   end

   // Trigger waits for settled lines and a waiting device
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_pend_r    <= 1'b0;
         chg_tmr_r      <= '0;
         hold_tmr_r     <= '0;
         lnk.frame_trig <= 1'b0;
      end else begin
         if (do_wr && wa_r == OFS_LINES && hold_tmr_r == '0) begin
            chg_tmr_r <= TW'(SETTLE_CYC);                  // [RULE14]
         end else if (chg_tmr_r != '0) begin
            chg_tmr_r <= chg_tmr_r - 1'b1;
         end
         if (hold_tmr_r != '0) begin
            hold_tmr_r <= hold_tmr_r - 1'b1;
         end else begin
            lnk.frame_trig <= 1'b0;
         end
         if (trig_pend_r && chg_tmr_r == '0 && hold_tmr_r == '0 && !lnk.frame_trig && lnk.waiting && !do_wr) begin
            lnk.frame_trig <= 1'b1;                        // [RULE16]
            hold_tmr_r     <= TW'(SETTLE_CYC);             // [RULE14]
            trig_pend_r    <= 1'b0;
         end
         if (do_wr && wa_r == OFS_CMD && wc.trig) begin
            trig_pend_r <= 1'b1;
         end
      end
   end

   //---------------------------------------------------------------
   // Read channel
   //---------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arready_o <= 1'b0;
         rvalid_o  <= 1'b0;
         rdata_o   <= 32'h0000_0000;
         rresp_o   <= RESP_OK;
      end else begin
         arready_o <= ~rvalid_o & ~(arvalid_i & arready_o);
         if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rresp_o  <= RESP_OK;
            if (araddr_i == OFS_CTRL) begin
               rdata_o <= 32'(lnk.cfg);
            end else if (araddr_i == OFS_LINES) begin
               rdata_o <= 32'(lnk.lines);
            end else if (araddr_i == OFS_CMD) begin
               rdata_o <= 32'h0000_0000;
            end else if (araddr_i == OFS_PARAM) begin
               rdata_o <= 32'(lnk.param_wdata);
            end else if (araddr_i == OFS_STATUS) begin
               rdata_o <= {lnk.act_param, 2'h0, lnk.act_idx, 6'h00, trig_pend_r, lnk.waiting};
            end else begin
               rdata_o <= 32'h0000_0000;
               rresp_o <= RESP_ERR;
            end
         end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: rtl/pss_if.sv
// Link between the host controller and the sequencer device
`timescale 1ns/1ps
`default_nettype none
interface pss_if;
   import pss_pkg::*;
   pss_lines_t    lines;
   logic          frame_trig;
   pss_ctrl_t     cfg;
   pss_cmd_t      cmd;
   logic [PW-1:0] param_wdata;
   logic          waiting;
   logic [PW-1:0] act_param;
   logic [IW-1:0] act_idx;
   modport dev  (input lines, frame_trig, cfg, cmd, param_wdata, output waiting, act_param, act_idx);
   modport host (output lines, frame_trig, cfg, cmd, param_wdata, input waiting, act_param, act_idx);
endinterface
`default_nettype wire

// file: rtl/pss_pkg.sv
// Constants and types shared by the parameter set sequencer ends
//------------------------------------------------------------------
// Overview of operation
// [RULE1] Controlled mode: up to 64 stored sets
// [RULE2] Advance source: always, line, control bits, off
// [RULE3] Target selects advance or restart; restart never always
// [RULE4] Host never gives advance and restart one source
// [RULE5] Set pointer accepts 0 through 63
// [RULE6] Unwritten sets read as default values
// [RULE7] Save copies active set into pointed slot
// [RULE8] Host disables sequencer before changing configuration
// [RULE9] Restore copies pointed slot into active set
// [RULE10] Free mode: trigger samples address, loads set
// [RULE11] Free mode: up to 4 stored sets
// [RULE12] Two sets use one address line only
// [RULE13] Line bit 0, control bit a bit 1
// [RULE14] Host settles address lines 1 us around trigger
// [RULE15] Address line change drops waiting, ignores triggers
// [RULE16] Host triggers only while device is waiting
// [RULE17] Disable mid frame: finish, then restore active
// [RULE18] Disabled source: only async advance and restart
// [RULE19] Address is plain binary, bit 1 high
// [RULE20] Inverted address input reads low as one
// [RULE21] Pins synchronised before edge detect and sampling
// [RULE22] Pointer at or above count is ignored
//------------------------------------------------------------------
package pss_pkg;
   localparam int PW          = 16;
   localparam int IW          = 6;
   localparam int CW          = 7;
   localparam int NSET        = 64;
   localparam int SW          = 3;
   localparam logic [CW-1:0] MAX_CTRL = 7'h40;
   localparam logic [CW-1:0] MAX_FREE = 7'h04;
   localparam logic [CW-1:0] TWO_SETS = 7'h02;
   localparam logic [PW-1:0] DEF_PARAM = 16'h0000;
   localparam logic [IW-1:0] IDX_ONE   = 6'h01;
   // Control sources
   localparam logic [SW-1:0] SRC_OFF    = 3'h0;
   localparam logic [SW-1:0] SRC_ALWAYS = 3'h1;
   localparam logic [SW-1:0] SRC_LINE1  = 3'h2;
   localparam logic [SW-1:0] SRC_CCA    = 3'h3;
   localparam logic [SW-1:0] SRC_CCB    = 3'h4;
   localparam logic [SW-1:0] SRC_CCC    = 3'h5;
   // Timing
   localparam int CLK_PS      = 5000;
   localparam int SETTLE_US   = 1;
   localparam int SETTLE_CYC  = (SETTLE_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int TW          = 9;
   localparam int FRAME_CYC   = 32;
   // Host register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_LINES  = 8'h04;
   localparam logic [7:0] OFS_CMD    = 8'h08;
   localparam logic [7:0] OFS_PARAM  = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [1:0] RESP_OK    = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;
   typedef struct packed {
      logic [IW-1:0] ptr;
      logic [CW-1:0] count;
      logic          inv1;
      logic          inv0;
      logic [1:0]    a1sel;
      logic [1:0]    a0sel;
      logic [SW-1:0] src;
      logic          target;
      logic          free;
      logic          on;
   } pss_ctrl_t;
   typedef struct packed {
      logic param_wr;
      logic trig;
      logic restart;
      logic advance;
      logic load;
      logic store;
      logic src_wr;
   } pss_cmd_t;
   typedef struct packed {
      logic c;
      logic b;
      logic a;
      logic line1;
   } pss_lines_t;
   typedef enum logic [1:0] {
      PSS_WAIT   = 2'b00,
      PSS_FRAME  = 2'b01,
      PSS_LOAD   = 2'b11,
      PSS_SETTLE = 2'b10
   } pss_state_t;
endpackage

// file: rtl/pss_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module pss_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta_r[g] <= 1'b0;
               q_o[g]    <= 1'b0;
            end else begin
               meta_r[g] <= d_i[g];
               q_o[g]    <= meta_r[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire
